// file: hw/arrc_top.sv
// rate/mode and reference control registers with their decode,
// modulator clock tick, conversion timing and chop averaging.
// assumes the serial command decoder delivers one-cycle register
// strobes synchronous to the 125 MHz clock.
`timescale 1ns/1ps

module arrc_top #(
    parameter int DATA_W = 24,
    parameter int RATE_BASE_TICKS = arrc_pkg::ARRC_RATE_BASE_TICKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port from the command decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // conversion control
    input wire logic start_req,
    input wire logic power_down,
    input wire logic ext_clk_tick,
    input wire logic [2:0] conv_delay_code,
    // raw results from the filter core
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    // register contents
    output arrc_pkg::arrc_rate_cfg_s rate_cfg,
    output arrc_pkg::arrc_ref_cfg_s ref_cfg,
    // decoded analog controls
    output logic clk_ext_sel,
    output logic sinc3_sel,
    output logic low_latency_sel,
    output logic ref_low_mon_en,
    output logic ref_mid_mon_en,
    output logic ref_pull_together_en,
    output logic pos_ref_buffer_bypass,
    output logic neg_ref_buffer_bypass,
    output logic ref_src_ext0,
    output logic ref_src_ext1,
    output logic ref_src_internal,
    output logic int_ref_on,
    // conversion timing and results
    output logic mod_tick,
    output logic filter_reset,
    output logic conv_busy,
    output logic conv_ready,
    output logic chop_swap,
    output logic result_valid,
    output logic [DATA_W-1:0] result_data
);
    import arrc_pkg::*;

    if (RATE_BASE_TICKS < 16)
    begin : g_chk
        $error("arrc_top: RATE_BASE_TICKS too small");
    end

    localparam logic [ARRC_ACC_W-1:0] OSC_STEP =
        ARRC_ACC_W'(ARRC_OSC_FREQ_KHZ);
    localparam logic [ARRC_ACC_W-1:0] OSC_WRAP =
        ARRC_ACC_W'(ARRC_SYS_FREQ_KHZ);
    localparam int DIV_W = $clog2(ARRC_MOD_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ARRC_MOD_DIV - 1);

    arrc_rate_cfg_s rate_ff;
    arrc_ref_cfg_s ref_ff;
    logic wr_rate;
    logic wr_ref;
    logic cfg_change;
    logic restart_ff;
    logic [ARRC_ACC_W-1:0] acc_ff;
    logic [ARRC_ACC_W-1:0] nxt_acc;
    logic osc_tick;
    logic src_tick;
    logic [DIV_W-1:0] div_ff;
    logic mod_tick_ff;

    // address decode
    assign wr_rate = reg_wr_en && (reg_addr == ARRC_ADDR_RATE);
    assign wr_ref = reg_wr_en && (reg_addr == ARRC_ADDR_REF);

    // only a write that alters a setting restarts the conversion
    assign cfg_change = (wr_rate && (reg_wr_data != rate_ff))
                     || (wr_ref && (reg_wr_data != ref_ff));

    // rate/mode register; stores every code, reserved ones included
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rate_ff <= ARRC_RST_RATE;
        else if (wr_rate)
            rate_ff <= reg_wr_data;
    end

    // reference control register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            ref_ff <= ARRC_RST_REF;
        else if (wr_ref)
            ref_ff <= reg_wr_data;
    end

    assign rate_cfg = rate_ff;
    assign ref_cfg = ref_ff;

    // read data registered; unmapped addresses return zero
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rd_data <= ARRC_READ_ZERO;
        else if (reg_rd_en)
        begin
            if (reg_addr == ARRC_ADDR_RATE)
                reg_rd_data <= rate_ff;
            else if (reg_addr == ARRC_ADDR_REF)
                reg_rd_data <= ref_ff;
            else
                reg_rd_data <= ARRC_READ_ZERO;
        end
    end

    // registered decode of the mode bits
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_ext_sel <= 1'b0;
            sinc3_sel <= 1'b0;
            low_latency_sel <= 1'b1;
        end
        else
        begin
            clk_ext_sel <= rate_ff.clk_ext;
            sinc3_sel <= !rate_ff.low_latency;
            low_latency_sel <= rate_ff.low_latency;
        end
    end

    // reference monitor decode
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_low_mon_en <= 1'b0;
            ref_mid_mon_en <= 1'b0;
            ref_pull_together_en <= 1'b0;
        end
        else
        begin
            unique case (arrc_mon_e'(ref_ff.ref_monitor_config))
                ARRC_MON_OFF:
                begin
                    ref_low_mon_en <= 1'b0;
                    ref_mid_mon_en <= 1'b0;
                    ref_pull_together_en <= 1'b0;
                end
                ARRC_MON_LOW:
                begin
                    ref_low_mon_en <= 1'b1;
                    ref_mid_mon_en <= 1'b0;
                    ref_pull_together_en <= 1'b0;
                end
                ARRC_MON_LOW_MID:
                begin
                    ref_low_mon_en <= 1'b1;
                    ref_mid_mon_en <= 1'b1;
                    ref_pull_together_en <= 1'b0;
                end
                ARRC_MON_LOW_PULL:
                begin
                    ref_low_mon_en <= 1'b1;
                    ref_mid_mon_en <= 1'b0;
                    ref_pull_together_en <= 1'b1;
                end
            endcase
        end
    end

    // buffers and source; reserved source code selects nothing, so
    // the converter never sees two references shorted together
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pos_ref_buffer_bypass <= 1'b0;
            neg_ref_buffer_bypass <= 1'b1;
            ref_src_ext0 <= 1'b1;
            ref_src_ext1 <= 1'b0;
            ref_src_internal <= 1'b0;
        end
        else
        begin
            pos_ref_buffer_bypass <= ref_ff.pos_ref_buffer_bypass;
            neg_ref_buffer_bypass <= ref_ff.neg_ref_buffer_bypass;
            ref_src_ext0 <= (ref_ff.ref_source_select == ARRC_SRC_EXT0);
            ref_src_ext1 <= (ref_ff.ref_source_select == ARRC_SRC_EXT1);
            ref_src_internal <=
                (ref_ff.ref_source_select == ARRC_SRC_INT);
        end
    end

    // internal reference power; the buffer bypass advice is left to
    // software, hardware does not force it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            int_ref_on <= 1'b0;
        else
        begin
            unique case (arrc_pwr_e'(ref_ff.internal_ref_power_config))
                ARRC_PWR_ON_PD_OFF: int_ref_on <= !power_down;
                ARRC_PWR_ALWAYS: int_ref_on <= 1'b1;
                ARRC_PWR_OFF, ARRC_PWR_RSVD: int_ref_on <= 1'b0;
            endcase
        end
    end

    // fractional divider: exact 4.096 mhz mean rate from 125 mhz
    always_comb
    begin
        nxt_acc = acc_ff + OSC_STEP;
        if (nxt_acc >= OSC_WRAP)
            nxt_acc = nxt_acc - OSC_WRAP;
    end
    assign osc_tick = (acc_ff + OSC_STEP) >= OSC_WRAP;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            acc_ff <= '0;
        else
            acc_ff <= nxt_acc;
    end

    // clock source mux, then divide down to the modulator rate
    assign src_tick = rate_ff.clk_ext ? ext_clk_tick : osc_tick;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            div_ff <= '0;
            mod_tick_ff <= 1'b0;
        end
        else
        begin
            mod_tick_ff <= src_tick && (div_ff == DIV_LAST);
            if (src_tick)
                div_ff <= div_ff + DIV_W'(1);
        end
    end
    assign mod_tick = mod_tick_ff;

    // filter reset pulse on a setting change or a start request
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            restart_ff <= 1'b0;
        else
            restart_ff <= !power_down && (cfg_change || start_req);
    end
    assign filter_reset = restart_ff;

    arrc_conv_seq #(
        .RATE_BASE_TICKS(RATE_BASE_TICKS)
    ) u_seq (
        .clock(clock),
        .resetn(resetn),
        .mod_tick(mod_tick_ff),
        .restart(restart_ff),
        .stop(power_down),
        .single_shot(rate_ff.single_shot),
        .rate_select_code(rate_ff.rate_select_code),
        .conv_delay_code(conv_delay_code),
        .conv_ready(conv_ready),
        .busy(conv_busy)
    );

    arrc_chop_avg #(
        .DATA_W(DATA_W)
    ) u_chop (
        .clock(clock),
        .resetn(resetn),
        .chop_en(rate_ff.chop_en),
        .flush(restart_ff),
        .raw_valid(raw_valid),
        .raw_data(raw_data),
        .chop_swap(chop_swap),
        .result_valid(result_valid),
        .result_data(result_data)
    );

endmodule : arrc_top

// file: hw/arrc_pkg.sv
// package for the rate/mode and reference control register pair.
// assumes a single 125 MHz system clock and an 8-bit register port.
package arrc_pkg;

    // register addresses and reset values
    localparam logic [7:0] ARRC_ADDR_RATE = 8'h04;
    localparam logic [7:0] ARRC_ADDR_REF = 8'h05;
    localparam logic [7:0] ARRC_RST_RATE = 8'h14;
    localparam logic [7:0] ARRC_RST_REF = 8'h10;
    localparam logic [7:0] ARRC_READ_ZERO = 8'h00;

    // rate/mode register layout, msb first
    typedef struct packed {
        logic chop_en;                // bit 7, global chop
        logic clk_ext;                // bit 6, 1 selects external clock
        logic single_shot;            // bit 5, 1 selects single-shot
        logic low_latency;            // bit 4, 1 selects low-latency filter
        logic [3:0] rate_select_code; // bits 3:0
    } arrc_rate_cfg_s;

    // reference control register layout, msb first
    typedef struct packed {
        logic [1:0] ref_monitor_config;        // bits 7:6
        logic pos_ref_buffer_bypass;           // bit 5
        logic neg_ref_buffer_bypass;           // bit 4
        logic [1:0] ref_source_select;         // bits 3:2
        logic [1:0] internal_ref_power_config; // bits 1:0
    } arrc_ref_cfg_s;

    // reference monitor codes
    typedef enum logic [1:0] {
        ARRC_MON_OFF = 2'b00,
        ARRC_MON_LOW = 2'b01,
        ARRC_MON_LOW_MID = 2'b10,
        ARRC_MON_LOW_PULL = 2'b11
    } arrc_mon_e;

    // reference source codes
    typedef enum logic [1:0] {
        ARRC_SRC_EXT0 = 2'b00,
        ARRC_SRC_EXT1 = 2'b01,
        ARRC_SRC_INT = 2'b10,
        ARRC_SRC_RSVD = 2'b11
    } arrc_src_e;

    // internal reference power codes
    typedef enum logic [1:0] {
        ARRC_PWR_OFF = 2'b00,
        ARRC_PWR_ON_PD_OFF = 2'b01,
        ARRC_PWR_ALWAYS = 2'b10,
        ARRC_PWR_RSVD = 2'b11
    } arrc_pwr_e;

    // clocking: internal oscillator synthesised from the system clock
    localparam int ARRC_SYS_FREQ_KHZ = 125000;
    localparam int ARRC_OSC_FREQ_KHZ = 4096;  // 4.096 MHz oscillator
    localparam int ARRC_MOD_DIV = 16;         // t_mod = 16 oscillator cycles
    localparam int ARRC_ACC_W = $clog2(ARRC_SYS_FREQ_KHZ + ARRC_OSC_FREQ_KHZ);

    // output period at rate code 0000 (2.5 sps) in t_mod units
    localparam int ARRC_MOD_FREQ_HZ = ARRC_OSC_FREQ_KHZ * 1000 / ARRC_MOD_DIV;
    localparam int ARRC_RATE_BASE_TICKS = ARRC_MOD_FREQ_HZ * 2 / 5;

    localparam int ARRC_TICK_W = 24;

    // conversion delay after a restart, in t_mod units
    function automatic logic [ARRC_TICK_W-1:0] arrc_delay_ticks(
        input logic [2:0] code
    );
        logic [ARRC_TICK_W-1:0] t;
        t = 24'h00_1000;
        unique case (code)
            3'h0: t = 24'h00_000E;   // 14
            3'h1: t = 24'h00_0019;   // 25
            3'h2: t = 24'h00_0040;   // 64
            3'h3: t = 24'h00_0100;   // 256
            3'h4: t = 24'h00_0400;   // 1024
            3'h5: t = 24'h00_0800;   // 2048
            3'h6: t = 24'h00_1000;   // 4096
            3'h7: t = 24'h00_1000;
        endcase
        return t;
    endfunction : arrc_delay_ticks

    // sequencer states
    typedef enum logic [1:0] {
        ARRC_SEQ_IDLE = 2'b00,
        ARRC_SEQ_DELAY = 2'b01,
        ARRC_SEQ_CONV = 2'b10
    } arrc_seq_e;

endpackage : arrc_pkg

// file: hw/arrc_conv_seq.sv
// conversion timing sequencer: first-result delay, then one period per
// result. assumes a one-cycle modulator tick enable from the parent.
`timescale 1ns/1ps
module arrc_conv_seq #(
    parameter int RATE_BASE_TICKS = arrc_pkg::ARRC_RATE_BASE_TICKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // control
    input wire logic mod_tick,
    input wire logic restart,
    input wire logic stop,
    input wire logic single_shot,
    input wire logic [3:0] rate_select_code,
    input wire logic [2:0] conv_delay_code,
    // status
    output logic conv_ready,
    output logic busy
);
    import arrc_pkg::*;

    if (RATE_BASE_TICKS < 16 || RATE_BASE_TICKS >= (1 << ARRC_TICK_W))
    begin : g_chk
        $error("arrc_conv_seq: RATE_BASE_TICKS out of range");
    end

    localparam logic [ARRC_TICK_W-1:0] BASE_T =
        ARRC_TICK_W'(RATE_BASE_TICKS);

    arrc_seq_e state_ff;
    logic [ARRC_TICK_W-1:0] cnt_ff;
    logic [ARRC_TICK_W-1:0] period;
    logic cnt_end;

    // each rate code halves the period; never below one tick
    assign period = ((BASE_T >> rate_select_code) == '0) ?
        ARRC_TICK_W'(1) : (BASE_T >> rate_select_code);
    assign cnt_end = mod_tick && (cnt_ff <= ARRC_TICK_W'(1));
    assign busy = (state_ff != ARRC_SEQ_IDLE);

    // state and tick counter; restart wins over everything but stop
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ARRC_SEQ_IDLE;
            cnt_ff <= '0;
        end
        else if (stop)
        begin
            state_ff <= ARRC_SEQ_IDLE;
            cnt_ff <= '0;
        end
        else if (restart)
        begin
            state_ff <= ARRC_SEQ_DELAY;
            cnt_ff <= arrc_delay_ticks(conv_delay_code);
        end
        else
        begin
            unique case (state_ff)
                ARRC_SEQ_IDLE: cnt_ff <= '0;
                ARRC_SEQ_DELAY, ARRC_SEQ_CONV:
                begin
                    if (cnt_end)
                    begin
                        // single-shot ends after one result
                        state_ff <= single_shot ? ARRC_SEQ_IDLE
                                                : ARRC_SEQ_CONV;
                        cnt_ff <= period;
                    end
                    else if (mod_tick)
                        cnt_ff <= cnt_ff - ARRC_TICK_W'(1);
                end
                default:
                begin
                    state_ff <= ARRC_SEQ_IDLE;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // one-cycle result strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            conv_ready <= 1'b0;
        else
            conv_ready <= !stop && !restart && busy && cnt_end;
    end

endmodule : arrc_conv_seq

// file: hw/arrc_chop_avg.sv
// global chop: swaps input polarity per result and averages pairs.
// assumes raw results arrive as one-cycle valid strobes.
`timescale 1ns/1ps
module arrc_chop_avg #(
    parameter int DATA_W = 24
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // control
    input wire logic chop_en,
    input wire logic flush,
    // raw results from the filter
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    // averaged output
    output logic chop_swap,
    output logic result_valid,
    output logic [DATA_W-1:0] result_data
);
    if (DATA_W < 2 || DATA_W > 32)
    begin : g_chk
        $error("arrc_chop_avg: DATA_W out of range");
    end

    logic [DATA_W-1:0] first_ff;
    logic [DATA_W:0] diff;

    // second reading is taken swapped, so subtract to cancel offset
    assign diff = {first_ff[DATA_W-1], first_ff}
                - {raw_data[DATA_W-1], raw_data};

    // swap toggles after each reading; flush restarts the pair
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            chop_swap <= 1'b0;
        else if (flush || !chop_en)
            chop_swap <= 1'b0;
        else if (raw_valid)
            chop_swap <= !chop_swap;
    end

    // hold the first reading of a pair
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            first_ff <= '0;
        else if (raw_valid && !chop_swap)
            first_ff <= raw_data;
    end

    // output register: passthrough, or mean of the pair
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            result_valid <= 1'b0;
            result_data <= '0;
        end
        else
        begin
            result_valid <= 1'b0;
            if (raw_valid && !flush && !chop_en)
            begin
                result_valid <= 1'b1;
                result_data <= raw_data;
            end
            else if (raw_valid && !flush && chop_swap)
            begin
                result_valid <= 1'b1;
                result_data <= diff[DATA_W:1];
            end
        end
    end

endmodule : arrc_chop_avg

// file: verif/arrc_top_monitor.sv
// checker for the rate/mode and reference register pair.
// assumes it is bound into arrc_top and sees only that module's ports.
`timescale 1ns/1ps
module arrc_top_monitor #(
    parameter int DATA_W = 24
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register write port and power state
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic power_down,
    // raw results
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    // register contents
    input wire arrc_pkg::arrc_rate_cfg_s rate_cfg,
    input wire arrc_pkg::arrc_ref_cfg_s ref_cfg,
    // decoded controls
    input wire logic clk_ext_sel,
    input wire logic sinc3_sel,
    input wire logic low_latency_sel,
    input wire logic ref_low_mon_en,
    input wire logic ref_mid_mon_en,
    input wire logic ref_pull_together_en,
    input wire logic pos_ref_buffer_bypass,
    input wire logic neg_ref_buffer_bypass,
    input wire logic ref_src_internal,
    input wire logic int_ref_on,
    // conversion and results
    input wire logic filter_reset,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data
);
    import arrc_pkg::*;

    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // mapped writes land one edge later
    chk_rate_write_lands: assert property (
        reg_wr_en && reg_addr == 8'h04 |=> rate_cfg == $past(reg_wr_data))
        else $error("rate register missed a write");
    chk_ref_write_lands: assert property (
        reg_wr_en && reg_addr == 8'h05 |=> ref_cfg == $past(reg_wr_data))
        else $error("reference register missed a write");
    // without a write nothing may move
    chk_regs_hold: assert property (
        !reg_wr_en |=> $stable(rate_cfg) && $stable(ref_cfg))
        else $error("register changed without a write");
    // decodes follow the written bits two edges on
    chk_rate_decode: assert property (
        reg_wr_en && reg_addr == 8'h04 |=> ##1
        clk_ext_sel == $past(reg_wr_data[6], 2) &&
        sinc3_sel == !$past(reg_wr_data[4], 2) &&
        low_latency_sel == $past(reg_wr_data[4], 2))
        else $error("rate decode wrong");
    chk_ref_decode: assert property (
        reg_wr_en && reg_addr == 8'h05 |=> ##1
        {pos_ref_buffer_bypass, neg_ref_buffer_bypass} ==
        $past(reg_wr_data[5:4], 2) &&
        ref_src_internal == ($past(reg_wr_data[3:2], 2) == 2'b10))
        else $error("reference decode wrong");
    chk_monitor_decode: assert property (
        ref_low_mon_en == ($past(ref_cfg.ref_monitor_config) != 2'b00) &&
        ref_mid_mon_en == ($past(ref_cfg.ref_monitor_config) == 2'b10) &&
        ref_pull_together_en == ($past(ref_cfg.ref_monitor_config) == 2'b11))
        else $error("monitor decode wrong");
    chk_int_ref_power: assert property (
        int_ref_on == ($past(ref_cfg.internal_ref_power_config) == 2'b10 ||
        ($past(ref_cfg.internal_ref_power_config) == 2'b01 &&
        !$past(power_down))))
        else $error("internal reference power wrong");
    // a changed rate setting restarts the filter one edge later
    chk_restart_pulse: assert property (
        reg_wr_en && reg_addr == 8'h04 && reg_wr_data != rate_cfg &&
        !power_down ##1 !power_down |-> filter_reset)
        else $error("no filter restart after change");
    // chop off: each raw result passes straight through
    chk_chop_off_pass: assert property (
        raw_valid && !rate_cfg.chop_en && !filter_reset |=>
        result_valid && result_data == $past(raw_data))
        else $error("raw result not passed through");
endmodule : arrc_top_monitor

bind arrc_top arrc_top_monitor #(.DATA_W(DATA_W)) u_mon (.*);

// file: verif/arrc_top_test.sv
// self-checking bench for arrc_top, driven at the falling edge.
// assumes the checker binds itself in.
`timescale 1ns/1ps
module arrc_top_test;
    import arrc_pkg::*;
    localparam int BASE = 64;
    logic clock, resetn, reg_wr_en, reg_rd_en, start_req, power_down;
    logic ext_clk_tick, raw_valid, filter_reset, conv_ready, chop_swap;
    logic result_valid, mod_tick, conv_busy, clk_ext_sel, sinc3_sel;
    logic low_latency_sel, ref_low_mon_en, ref_mid_mon_en, int_ref_on;
    logic ref_pull_together_en, pos_ref_buffer_bypass, ref_src_internal;
    logic neg_ref_buffer_bypass, ref_src_ext0, ref_src_ext1;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, a, d;
    logic [2:0] conv_delay_code;
    logic [23:0] raw_data, result_data, x, y;
    logic [24:0] df;
    arrc_rate_cfg_s rate_cfg;
    arrc_ref_cfg_s ref_cfg;
    int n_mismatch, compares, i, n, k, c;
    int m_reg [2];  // bench copy of rate and reference registers

    // shortened rate base keeps the run to a few thousand cycles
    arrc_top #(.RATE_BASE_TICKS(BASE)) dut (.*);

    // 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [23:0] got, input logic [23:0] exp,
        input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                exp);
        end
    endtask : check

    // write; a change must pulse restart
    task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
        logic chg;
        chg = (ad == 8'h04 && m_reg[0] != dd) ||
            (ad == 8'h05 && m_reg[1] != dd);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = ad;
        reg_wr_data = dd;
        @(negedge clock);
        reg_wr_en = 1'b0;
        check(24'(filter_reset), 24'(chg && !power_down), "restart");
        if (ad == 8'h04)
            m_reg[0] = dd;
        if (ad == 8'h05)
            m_reg[1] = dd;
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        int e;
        e = ad == 8'h04 ? m_reg[0] : ad == 8'h05 ? m_reg[1] : 0;
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = ad;
        @(negedge clock);
        reg_rd_en = 1'b0;
        check(24'(reg_rd_data), 24'(e[7:0]), "read");
    endtask : rd

    // decoded outputs against the bench copy of the registers
    task automatic chk_dec();
        int r, f, m, s, p;
        r = m_reg[0];
        f = m_reg[1];
        m = f >> 6;
        s = (f >> 2) & 3;
        p = f & 3;
        check(24'(clk_ext_sel), 24'(r[6]), "clk");
        check(24'({sinc3_sel, low_latency_sel}), 24'({!r[4], r[4]}), "flt");
        check(24'({ref_low_mon_en, ref_mid_mon_en, ref_pull_together_en}),
            24'({m != 0, m == 2, m == 3}), "mon");
        check(24'({pos_ref_buffer_bypass, neg_ref_buffer_bypass}),
            24'(f[5:4]), "buf");
        check(24'({ref_src_ext0, ref_src_ext1, ref_src_internal}),
            24'({s == 0, s == 1, s == 2}), "src");
        check(24'(int_ref_on), 24'(p == 2 || (p == 1 && !power_down)),
            "pwr");
    endtask : chk_dec

    task automatic wait_ready(input int lim, output int cnt);
        cnt = 0;
        while (conv_ready !== 1'b1)
        begin
            @(negedge clock);
            cnt++;
            if (cnt > lim)
            begin
                n_mismatch++;
                $display("wrong value at %0t: no result", $time);
                close_out();
            end
        end
    endtask : wait_ready

    task automatic raw(input logic [23:0] v);
        @(negedge clock);
        raw_valid = 1'b1;
        raw_data = v;
        @(negedge clock);
        raw_valid = 1'b0;
    endtask : raw

    // main sequence
    initial
    begin
        resetn = 1'b0;
        {reg_wr_en, reg_rd_en, start_req, power_down, raw_valid} = 5'h0;
        {reg_addr, reg_wr_data, raw_data} = 40'h0;
        ext_clk_tick = 1'b0;
        conv_delay_code = 3'h0;
        n_mismatch = 0;
        compares = 0;
        m_reg[0] = 'h14;
        m_reg[1] = 'h10;
        void'($urandom(51));
        repeat (12) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        rd(8'h04);
        rd(8'h05);
        chk_dec();
        $display("test reset done");
        // random writes, unmapped address 03h among them
        repeat (24)
        begin
            a = 8'h03 + 8'($urandom_range(0, 2));
            wr(a, 8'($urandom));
            rd(a);
        end
        $display("test readback done");
        // every code of the monitor, source and power fields, with and without power-down
        for (c = 0; c < 8; c++)
        begin
            d = 8'($urandom);
            // software side: bypass both buffers on the internal source
            wr(8'h05, {2'(c), (c[1:0] == 2) ? 2'b11 : d[5:4], 2'(c),
                2'(c)});
            wr(8'h04, {1'b0, c[0], 1'b0, c[1], d[3:0]});
            power_down = c[2];
            repeat (2) @(negedge clock);
            chk_dec();
        end
        $display("test decode done");
        // external clock ticking every cycle: t_mod is 16 cycles
        power_down = 1'b0;
        ext_clk_tick = 1'b1;
        wr(8'h04, 8'h14);
        for (i = 0; i < 3; i++)
        begin
            wr(8'h04, {4'b0101, 4'(i)});
            wait_ready(400, n);
            check(24'(n >= 204 && n <= 248), 24'h1, "delay");
            @(negedge clock);
            wait_ready(1200, n);
            check(24'(n + 1), 24'((BASE >> i) * 16), "period");
        end
        $display("test continuous done");
        // single-shot: one result per start, none in power-down
        wr(8'h04, 8'h72);
        for (i = 0; i < 3; i++)
        begin
            power_down = (i == 2);
            if (i > 0)
            begin
                @(negedge clock);
                start_req = 1'b1;
                @(negedge clock);
                start_req = 1'b0;
            end
            k = 0;
            repeat (1500)
            begin
                @(negedge clock);
                if (conv_ready === 1'b1)
                    k++;
            end
            check(24'(k), 24'(i < 2), "single");
            check(24'(conv_busy), 24'h0, "idle");
        end
        $display("test single-shot done");
        // chop on: pairs averaged with the second reading swapped
        power_down = 1'b0;
        wr(8'h04, 8'h94);
        repeat (6)
        begin
            x = 24'($urandom);
            y = 24'($urandom);
            raw(x);
            check(24'({chop_swap, result_valid}), 24'h2, "swap");
            raw(y);
            df = {x[23], x} - {y[23], y};
            check(24'({chop_swap, result_valid}), 24'h1, "pair");
            check(result_data, df[24:1], "avg");
        end
        wr(8'h04, 8'h14);
        repeat (4)
        begin
            x = 24'($urandom);
            raw(x);
            check(24'(result_valid), 24'h1, "pass");
            check(result_data, x, "data");
        end
        $display("test chop done");
        close_out();
    end
endmodule : arrc_top_test
